// file: hdl/adc_mode_map.vh
`ifndef ADC_MODE_MAP_VH
`define ADC_MODE_MAP_VH

// ----------------------------------------
// state request field encodings
// ----------------------------------------
`define MODE_SHUTDOWN 2'h0
`define MODE_STANDBY 2'h2
`define MODE_CONVERT 2'h3
`define MODE_RUN_BIT 1
`define MODE_CONV_BIT 0

// ----------------------------------------
// primary configuration register layout
// ----------------------------------------
`define CFG_MODE_LO 0
`define CFG_MODE_HI 1
`define CFG_TOP_LO 6
`define CFG_TOP_HI 7
`define CFG_RESET 8'hC0
`define CFG_FULL_SHUTDOWN 8'h00

// ----------------------------------------
// fast command codes
// ----------------------------------------
`define FC_CONVERT 4'hA
`define FC_STANDBY 4'hB
`define FC_SHUTDOWN 4'hC
`define FC_FULL_SHUTDOWN 4'hD
`define FC_FULL_RESET 4'hE

// ----------------------------------------
// timing
// ----------------------------------------
`define SETUP_PERIODS 9'h100
`define SYNC_DELAY 2'h2

`endif

// file: hdl/startup_timer.v
`timescale 1ns/1ps
`include "adc_mode_map.vh"

module startup_timer #(
	parameter CNT_W = 9
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// control
	input wire clear,
	input wire run,
	input wire tick,
	input wire sync_req,
	input wire mclk_tick,
	// status
	output wire done
);

reg [CNT_W-1:0] cnt_q;
reg [1:0] sync_q;

// ----------------------------------------
// settling counter
// ----------------------------------------
always @(posedge clk or posedge rst) begin
	if (rst) begin
		cnt_q <= `SETUP_PERIODS;
		sync_q <= 2'h0;
	end else if (clear) begin
		cnt_q <= `SETUP_PERIODS;
		sync_q <= 2'h0;
	end else begin
		// spi requests wait two master clocks before counting
		if (sync_req)
			sync_q <= `SYNC_DELAY;
		else if (mclk_tick && sync_q != 2'h0)
			sync_q <= sync_q - 2'h1;
		if (run && tick && !sync_req && sync_q == 2'h0 && cnt_q != {CNT_W{1'b0}})
			cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
	end
end

assign done = (cnt_q == {CNT_W{1'b0}});

endmodule // startup_timer

// file: hdl/adc_mode_control.v
`timescale 1ns/1ps
`include "adc_mode_map.vh"

// How it works
// - field 11 is conversion, 10 standby, 0x shutdown
// - reset leaves the field at 00, so shutdown
// - field holds the request; live state shown separately after settling
// - from shutdown, conversion waits 256 divided clock periods
// - fast commands per state act like writing the field
// - single-channel rewrite of 11 restarts running conversion at once
// - sequencer: 11 launches scan; field reads 11 all cycle
// - sequencer rewrite of 11 restarts scan from first entry
// - restart while in gap shutdown inserts full settling
// - result register takes only completed conversions
// - every conversion end raises data-ready
// - result kept across states; cleared by reset or full-reset
// - shutdown acts at once; return needs full settling
// - standby stops conversions, converter held in reset, biased
// - conversion reached within settling; restart then immediate
// - full-shutdown when whole config written zero; host keeps top bits 11
// - full-shutdown fast command enters full-shutdown too
// - serial commands still accepted in full-shutdown
// - full-shutdown keeps result and configuration
// - sequencer gap shutdown never means full-shutdown
// - full-shutdown entry reloads internal timers; they stay halted only while the field is 0x or the ticks stop
// - leaving run states reloads start-up counter to 256
// - rewriting same value leaves counter alone
module adc_mode_control #(
	parameter DATA_W = 16,
	parameter CONV_CYCLES = 8'h20
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// timing ticks
	input wire mclk_tick,
	input wire divided_master_clock_tick,
	// register write port
	input wire cfg_wr,
	input wire [7:0] cfg_wdata,
	// fast commands
	input wire fast_cmd,
	input wire [3:0] fast_code,
	// configuration
	input wire single_channel_mode,
	input wire start_pulse_enable,
	// sequencer
	input wire scan_end,
	input wire gap_shutdown,
	// converter data
	input wire [DATA_W-1:0] conv_data,
	// status and results
	output reg [7:0] primary_config_register,
	output reg [1:0] live_state,
	output reg converting,
	output reg conv_reset,
	output reg start_pulse,
	output reg data_ready,
	output reg scan_restart,
	output reg full_shutdown,
	output reg [DATA_W-1:0] conversion_result_register
);

// ----------------------------------------
// live state codes
// ----------------------------------------
// state field decode
// the live codes reuse the field encodings, so a settled request copies straight across
localparam ST_SHUT = 2'h0;
localparam ST_STBY = 2'h2;
localparam ST_CONV = 2'h3;

// both 0x patterns mean shutdown, so only the upper bit decides run or not
function is_run;
	input [1:0] m;
	begin
		is_run = m[`MODE_RUN_BIT];
	end
endfunction

reg [1:0] req_mode;
reg req_spi;
reg req_any;
reg [7:0] conv_cnt_q;
reg scan_active_q;
reg prev_live_conv;
wire timer_done;
wire timer_clear;
wire restart;
wire fs_enter;

// ----------------------------------------
// request decode
// ----------------------------------------
always @* begin
	req_any = 1'b0;
	req_spi = 1'b0;
	req_mode = primary_config_register[`CFG_MODE_HI:`CFG_MODE_LO];
	if (cfg_wr) begin
		req_any = 1'b1;
		req_spi = 1'b1;
		req_mode = cfg_wdata[`CFG_MODE_HI:`CFG_MODE_LO];
	end else if (fast_cmd) begin
		case (fast_code)
			`FC_CONVERT: begin
				req_any = 1'b1;
				req_spi = 1'b1;
				req_mode = `MODE_CONVERT;
			end
			`FC_STANDBY: begin
				req_any = 1'b1;
				req_spi = 1'b1;
				req_mode = `MODE_STANDBY;
			end
			`FC_SHUTDOWN: begin
				req_any = 1'b1;
				req_spi = 1'b1;
				req_mode = `MODE_SHUTDOWN;
			end
			default: begin
				req_any = 1'b0;
			end
		endcase
	end
end

// rewrite of 11 while active restarts
assign restart = req_any && req_mode == `MODE_CONVERT &&
	primary_config_register[`CFG_MODE_HI:`CFG_MODE_LO] == `MODE_CONVERT;

// full-shutdown entry; gap shutdown is internal only
assign fs_enter = (cfg_wr && cfg_wdata == `CFG_FULL_SHUTDOWN) ||
	(fast_cmd && fast_code == `FC_FULL_SHUTDOWN);

// reload on shutdown or full-shutdown; gap too
assign timer_clear = !is_run(req_mode) || fs_enter ||
	(scan_active_q && !single_channel_mode && gap_shutdown && !restart);

// ----------------------------------------
// settling timer
// ----------------------------------------
startup_timer #(
	.CNT_W(9)
) u_timer (
	.clk(clk),
	.rst(rst),
	.clear(timer_clear),
	.run(is_run(req_mode)),
	.tick(divided_master_clock_tick),
	// same value rewrite only adds sync delay
	.sync_req(req_spi && is_run(req_mode)),
	.mclk_tick(mclk_tick),
	.done(timer_done)
);

// ----------------------------------------
// configuration and full-shutdown
// ----------------------------------------
always @(posedge clk or posedge rst) begin
	if (rst) begin
		primary_config_register <= `CFG_RESET & 8'hFC;
		full_shutdown <= 1'b0;
		scan_active_q <= 1'b0;
		scan_restart <= 1'b0;
	end else begin
		scan_restart <= 1'b0;
		if (cfg_wr)
			primary_config_register <= cfg_wdata;
		else if (req_any)
			primary_config_register[`CFG_MODE_HI:`CFG_MODE_LO] <= req_mode;
		if (fs_enter)
			full_shutdown <= 1'b1;
		else if (req_any && is_run(req_mode))
			full_shutdown <= 1'b0;
		else if (cfg_wr && cfg_wdata != `CFG_FULL_SHUTDOWN)
			full_shutdown <= 1'b0;
		// field keeps 11 for whole scan, gap included
		if (req_any && !single_channel_mode)
			scan_active_q <= (req_mode == `MODE_CONVERT);
		if (!single_channel_mode && req_any && req_mode == `MODE_CONVERT)
			scan_restart <= 1'b1;
	end
end

// ----------------------------------------
// live state and conversions
// ----------------------------------------
always @(posedge clk or posedge rst) begin
	if (rst) begin
		live_state <= ST_SHUT;
		converting <= 1'b0;
		conv_reset <= 1'b1;
		start_pulse <= 1'b0;
		data_ready <= 1'b0;
		conv_cnt_q <= 8'h00;
		prev_live_conv <= 1'b0;
		conversion_result_register <= {DATA_W{1'b0}};
	end else begin
		start_pulse <= 1'b0;
		data_ready <= 1'b0;
		prev_live_conv <= (live_state == ST_CONV);
		// live state follows request after settling
		case (live_state)
			ST_SHUT: begin
				if (is_run(req_mode) && timer_done && !timer_clear)
					live_state <= req_mode;
			end
			ST_STBY, ST_CONV: begin
				if (timer_clear)
					live_state <= ST_SHUT;
				// standby to conversion immediate once settled
				else if (timer_done)
					live_state <= req_mode;
			end
			default: begin
				live_state <= ST_SHUT;
			end
		endcase
		// converter held in reset outside conversion
		if (live_state != ST_CONV || timer_clear) begin
			converting <= 1'b0;
			conv_reset <= 1'b1;
			conv_cnt_q <= 8'h00;
		end else if (!converting || (restart && timer_done)) begin
			converting <= 1'b1;
			conv_reset <= 1'b0;
			conv_cnt_q <= 8'h00;
			start_pulse <= start_pulse_enable;
		end else if (conv_cnt_q == CONV_CYCLES - 8'h01) begin
			conversion_result_register <= conv_data;
			data_ready <= 1'b1;
			conv_cnt_q <= 8'h00;
			converting <= !(scan_end && single_channel_mode == 1'b0 && gap_shutdown);
			start_pulse <= start_pulse_enable;
		end else begin
			conv_cnt_q <= conv_cnt_q + 8'h01;
		end
		if (fast_cmd && fast_code == `FC_FULL_RESET)
			conversion_result_register <= {DATA_W{1'b0}};
	end
end

endmodule // adc_mode_control

// file: bench/host_side_model.sv
`timescale 1ns/1ps
module host_side_model (
	// state from the block
	input wire full_shutdown,
	// clock ticks and converter data
	output wire mclk_tick,
	output wire divided_master_clock_tick,
	output wire [15:0] conv_data
);
	assign mclk_tick = !full_shutdown;
	assign divided_master_clock_tick = !full_shutdown;
	assign conv_data = 16'h5A3C;
endmodule // host_side_model

// file: bench/adc_mode_control_assertions.sv
`timescale 1ns/1ps
module adc_mode_control_assertions #(
	parameter DATA_W = 16
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// requests
	input wire cfg_wr,
	input wire [7:0] cfg_wdata,
	input wire fast_cmd,
	input wire [3:0] fast_code,
	// results
	input wire [7:0] primary_config_register,
	input wire [1:0] live_state,
	input wire data_ready,
	input wire full_shutdown,
	input wire [DATA_W-1:0] conversion_result_register
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	reg [8:0] wait_q;
	// cycles bound ticks from above, so a cycle count is a safe floor
	always @(posedge clk or posedge rst) begin
		if (rst)
			wait_q <= 9'h000;
		else if (!primary_config_register[1] || full_shutdown)
			wait_q <= 9'h000;
		else if (!wait_q[8])
			wait_q <= wait_q + 9'h001;
	end
	AST_CFG_WRITE: assert property (cfg_wr |=> primary_config_register == $past(cfg_wdata))
		else $error("config write lost");
	AST_SHUT_NOW: assert property (cfg_wr && !cfg_wdata[1] |=> live_state == 2'h0)
		else $error("shutdown late");
	AST_SETTLE: assert property ($rose(live_state == 2'h3) |-> wait_q[8])
		else $error("conversion before settling");
	AST_IDLE: assert property (live_state == 2'h0 [*2] |-> !data_ready)
		else $error("data ready while shut");
	AST_RESULT: assert property ($changed(conversion_result_register) |-> data_ready || $past(fast_cmd))
		else $error("result changed without conversion");
	AST_FULL_CFG: assert property (cfg_wr && cfg_wdata == 8'h00 |=> full_shutdown)
		else $error("config zero missed");
	AST_FULL_FC: assert property (fast_cmd && !cfg_wr && fast_code == 4'hD |=> full_shutdown)
		else $error("full-shutdown command missed");
	AST_FULL_KEEP: assert property ($rose(full_shutdown) |-> $stable(conversion_result_register))
		else $error("result lost in full-shutdown");
	cover property (data_ready);
	cover property ($rose(full_shutdown));
	cover property ($rose(live_state == 2'h3));
endmodule // adc_mode_control_assertions
bind adc_mode_control adc_mode_control_assertions #(.DATA_W(DATA_W)) chk (.clk(clk), .rst(rst),
	.cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .fast_cmd(fast_cmd), .fast_code(fast_code),
	.primary_config_register(primary_config_register), .live_state(live_state),
	.data_ready(data_ready), .full_shutdown(full_shutdown),
	.conversion_result_register(conversion_result_register));

// file: bench/test_adc_mode_control.sv
`timescale 1ns/1ps
module test_adc_mode_control;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg cfg_wr = 1'b0;
	reg [7:0] cfg_wdata = 8'h00;
	reg fast_cmd = 1'b0;
	reg [3:0] fast_code = 4'h0;
	reg single = 1'b1;
	reg gap = 1'b0;
	wire mt, dt, fsd, crst, sp, dr, sr, cv;
	wire [15:0] cdata, res;
	wire [7:0] cfg;
	wire [1:0] ls;
	integer err_count = 0;
	integer comparisons = 0;
	integer n;
	always #25 clk = ~clk;
	host_side_model host (.full_shutdown(fsd), .mclk_tick(mt), .divided_master_clock_tick(dt), .conv_data(cdata));
	adc_mode_control dut (.clk(clk), .rst(rst), .mclk_tick(mt), .divided_master_clock_tick(dt), .cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata), .fast_cmd(fast_cmd), .fast_code(fast_code),
		.single_channel_mode(single), .start_pulse_enable(1'b1), .scan_end(1'b0),
		.gap_shutdown(gap), .conv_data(cdata), .primary_config_register(cfg),
		.live_state(ls), .converting(cv), .conv_reset(crst), .start_pulse(sp), .data_ready(dr),
		.scan_restart(sr), .full_shutdown(fsd), .conversion_result_register(res));
	task chk(input [79:0] what, input [15:0] seen, input [15:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task step;
		begin
			@(posedge clk);
			#1;
		end
	endtask
	task wr(input [7:0] d);
		begin
			cfg_wr = 1'b1;
			cfg_wdata = d;
			step;
			cfg_wr = 1'b0;
		end
	endtask
	task fc(input [3:0] c);
		begin
			fast_cmd = 1'b1;
			fast_code = c;
			step;
			fast_cmd = 1'b0;
		end
	endtask
	// from shutdown: settle, convert, then the result lands
	task settle_convert;
		begin
			wr(8'hC3);
			chk("field", cfg, 16'h00C3);
			n = 0;
			while (ls !== 2'h3 && n < 400) begin
				step;
				n = n + 1;
			end
			chk("settle", n >= 255 && n < 400, 1);
			n = 0;
			while (dr !== 1'b1 && n < 100) begin
				step;
				n = n + 1;
			end
			chk("ready", dr, 1);
			chk("result", res, 16'h5A3C);
		end
	endtask
	task t_restart;
		begin
			wr(8'hC3);
			n = 0;
			while (sp !== 1'b1 && n < 4) begin
				step;
				n = n + 1;
			end
			chk("restart", sp, 1);
			chk("running", cv, 1);
			single = 1'b0;
			wr(8'hC3);
			step;
			wr(8'hC3);
			n = 0;
			while (sr !== 1'b1 && n < 4) begin
				step;
				n = n + 1;
			end
			chk("scan", sr, 1);
			chk("scan field", cfg[1:0], 2'h3);
			single = 1'b1;
			$display("restart test done");
		end
	endtask
	// sequencer gap shutdown: no full-shutdown, and a restart settles in full
	task t_gap;
		begin
			single = 1'b0;
			wr(8'hC3);
			gap = 1'b1;
			step;
			step;
			chk("gap shut", ls, 2'h0);
			chk("gap field", cfg[1:0], 2'h3);
			chk("gap full", fsd, 0);
			gap = 1'b0;
			wr(8'hC3);
			n = 0;
			while (ls !== 2'h3 && n < 400) begin
				step;
				n = n + 1;
			end
			chk("gap settle", n >= 255 && n < 400, 1);
			single = 1'b1;
			$display("gap test done");
		end
	endtask
	task t_states;
		begin
			fc(4'hB);
			step;
			chk("stby field", cfg[1:0], 2'h2);
			chk("stopped", cv, 0);
			chk("stby", ls, 2'h2);
			chk("held", crst, 1);
			fc(4'hC);
			step;
			chk("shut", ls, 2'h0);
			chk("kept", res, 16'h5A3C);
			settle_convert;
			$display("state test done");
		end
	endtask
	task t_full;
		begin
			wr(8'h00);
			step;
			chk("full cfg", fsd, 1);
			chk("full res", res, 16'h5A3C);
			wr(8'hC0);
			chk("served", cfg, 16'h00C0);
			fc(4'hD);
			step;
			chk("full cmd", fsd, 1);
			fc(4'hE);
			step;
			chk("cleared", res, 16'h0000);
			$display("full-shutdown test done");
		end
	endtask
	task complete_run;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, err_count);
			if (err_count == 0 && comparisons > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		#150000;
		err_count = err_count + 1;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("reset", {cfg, 6'h00, ls}, 16'hC000);
		settle_convert;
		$display("start test done");
		t_restart;
		t_gap;
		t_states;
		t_full;
		complete_run;
	end
endmodule // test_adc_mode_control
